// ---- hdl/acro_pkg.sv ----
// package for the audio clock rate and output block
// assumes a single 250 MHz system clock and an AHB-Lite register port
package acro_pkg;
	// register byte offsets
	localparam logic [7:0] ACRO_OFF_CTRL = 8'h00;
	localparam logic [7:0] ACRO_OFF_VARI = 8'h04;
	localparam logic [7:0] ACRO_OFF_HOST = 8'h08;
	localparam logic [7:0] ACRO_OFF_WCLK = 8'h0c;
	localparam logic [7:0] ACRO_OFF_STAT = 8'h10;
	localparam logic [7:0] ACRO_OFF_INCR = 8'h14;
	// timing and rates
	localparam longint ACRO_SYS_HZ = 250000000;
	localparam longint ACRO_HZ_48 = 48000;
	localparam longint ACRO_HZ_441 = 44100;
	localparam longint ACRO_HZ_32 = 32000;
	localparam longint ACRO_TICKS_PER_FS = 512;
	localparam logic [31:0] ACRO_INC_48 = 32'((ACRO_HZ_48 * ACRO_TICKS_PER_FS
		* 64'h1_0000_0000) / ACRO_SYS_HZ);
	localparam logic [31:0] ACRO_INC_441 = 32'((ACRO_HZ_441
		* ACRO_TICKS_PER_FS * 64'h1_0000_0000) / ACRO_SYS_HZ);
	localparam logic [31:0] ACRO_INC_32 = 32'((ACRO_HZ_32 * ACRO_TICKS_PER_FS
		* 64'h1_0000_0000) / ACRO_SYS_HZ);
	// speed factors, unsigned q.20
	localparam logic [21:0] ACRO_F_ONE = 22'h10_0000;
	localparam logic [21:0] ACRO_F_FINE_DN = 22'h0f_fbe7;
	localparam logic [21:0] ACRO_F_FINE_UP = 22'h10_0419;
	localparam logic [21:0] ACRO_F_COARSE_DN = 22'h0f_5c29;
	localparam logic [21:0] ACRO_F_COARSE_UP = 22'h10_aaab;
	localparam logic [21:0] ACRO_F_VARI_STEP = 22'h00_0419;
	localparam logic signed [7:0] ACRO_VARI_MAX = 8'sh7d;
	localparam int ACRO_TRIM_SHIFT = 12;
	typedef enum logic [1:0] {
		ACRO_R48 = 2'b00, ACRO_R441 = 2'b01, ACRO_R32 = 2'b10
	} acro_rate_t;
	typedef enum logic [1:0] {
		ACRO_P_OFF = 2'b00, ACRO_P_DN = 2'b01, ACRO_P_UP = 2'b10
	} acro_pull_t;
	typedef enum logic [1:0] {
		ACRO_PM_LOCAL = 2'b00, ACRO_PM_HOST = 2'b01, ACRO_PM_VARI = 2'b10
	} acro_pmode_t;
	typedef enum logic [2:0] {
		ACRO_WC_OFF = 3'b000, ACRO_WC_PASS = 3'b001, ACRO_WC_X1 = 3'b010,
		ACRO_WC_X2 = 3'b011, ACRO_WC_X4 = 3'b100, ACRO_WC_X256 = 3'b101
	} acro_wc_t;
	typedef enum logic [1:0] {
		ACRO_DS_REF = 2'b00, ACRO_DS_LINK = 2'b01, ACRO_DS_X1 = 2'b10,
		ACRO_DS_X2 = 2'b11
	} acro_dsrc_t;
	typedef enum logic {
		ACRO_BUS_IDLE = 1'b0, ACRO_BUS_RD = 1'b1
	} acro_bus_t;
	// local control word, reset values below
	typedef struct packed {
		acro_dsrc_t dsrc;
		logic [2:0] clk_ref;
		logic wc_link;
		acro_pmode_t pmode;
		acro_pull_t coarse;
		acro_pull_t fine;
		acro_rate_t rate;
	} acro_ctrl_t;
	typedef struct packed {
		logic frame_internal;
		logic connected;
		acro_pull_t coarse;
		acro_pull_t fine;
		logic [2:0] proj_rate;
	} acro_host_t;
	localparam acro_ctrl_t ACRO_CTRL_RST = '{ACRO_DS_X1, 3'h0, 1'b0,
		ACRO_PM_LOCAL, ACRO_P_OFF, ACRO_P_OFF, ACRO_R48};
	localparam logic [11:0] ACRO_WCLK_RST = 12'h492;
	localparam logic [2:0] ACRO_REF_FRAME = 3'h0;
endpackage : acro_pkg

// ---- hdl/acro_nco.sv ----
// phase accumulator ticking at 512 times the audio sample rate
// assumes increment is stable or changes on any cycle
`timescale 1ns/10ps
module acro_nco
	import acro_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [31:0] i_inc,
	output logic o_tick
);
	logic [31:0] acc;
	logic tick;
	logic [31:0] next_acc;
	logic next_tick;

	// carry out gives an evenly spread tick with no phase jump on retune
	always_comb begin
		{next_tick, next_acc} = {1'b0, acc} + {1'b0, i_inc};
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			acc <= next_acc;
			tick <= next_tick;
		end
	end

	assign o_tick = tick;
endmodule : acro_nco

// ---- hdl/acro_clk_sel.sv ----
// glitch-free clock selector, one registered output
// assumes sources are square waves sampled on the system clock
`timescale 1ns/10ps
module acro_clk_sel
	import acro_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_src,
	input wire logic [2:0] i_sel,
	input wire logic [2:0] i_rst_sel,
	output logic o_clk
);
	logic [2:0] cur;
	logic parked;
	logic out;
	logic [2:0] next_cur;
	logic next_parked;
	logic next_out;

	// park low only once the old source is low, leave only while the
	// new one is low: no shortened high phase reaches the pin
	always_comb begin
		next_cur = cur;
		next_parked = parked;
		if (!parked && i_sel != cur && !i_src[cur]) begin
			next_parked = 1'b1;
		end else if (parked && !i_src[i_sel]) begin
			next_parked = 1'b0;
			next_cur = i_sel;
		end
		next_out = next_parked ? 1'b0 : i_src[next_cur];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur <= 3'h0;
			parked <= 1'b1;
			out <= 1'b0;
		end else begin
			cur <= next_cur;
			parked <= next_parked;
			out <= next_out;
		end
	end

	// i_rst_sel only documents the intended power-up source
	logic unused_rst_sel;
	assign unused_rst_sel = ^i_rst_sel;
	assign o_clk = out;
endmodule : acro_clk_sel

// ---- hdl/acro_top.sv ----
// audio sample clock generator with word clock and digital out clocks
// assumes synchronous pins, one 250 MHz clock and an AHB-Lite master
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module acro_top
	import acro_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_wc_in,
	input wire logic [5:0] i_ref_in,
	input wire logic i_link_clk,
	input wire logic [1:0] i_dig_link_data,
	output logic o_word_clock_out_a,
	output logic o_word_clock_out_b,
	output logic o_word_clock_out_c,
	output logic o_word_clock_out_d,
	output logic o_dig_clk,
	output logic [1:0] o_dig_link_data
);
	// register state
	acro_ctrl_t ctrl;
	acro_ctrl_t next_ctrl;
	logic signed [7:0] vari;
	logic signed [7:0] next_vari;
	acro_host_t host;
	acro_host_t next_host;
	logic [11:0] wclk;
	logic [11:0] next_wclk;
	// bus state
	acro_bus_t bus_st;
	acro_bus_t next_bus_st;
	logic wr_pend;
	logic next_wr_pend;
	logic [7:0] addr;
	logic [7:0] next_addr;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic ready;
	logic next_ready;
	// read back by the bus, driven further down
	logic [31:0] inc;
	logic [31:0] stat_word;

	function automatic acro_rate_t proj_to_base(input logic [2:0] code);
		// 0:32k 1:44.1k 2:48k 3:88.2k 4:96k 5:176.4k 6:192k
		case (code)
			3'h0: proj_to_base = ACRO_R32;
			3'h1, 3'h3, 3'h5: proj_to_base = ACRO_R441;
			default: proj_to_base = ACRO_R48;
		endcase
	endfunction : proj_to_base

	function automatic logic [21:0] pull_factor(input acro_pull_t p,
		input logic coarse);
		case (p)
			ACRO_P_DN: pull_factor = coarse ? ACRO_F_COARSE_DN : ACRO_F_FINE_DN;
			ACRO_P_UP: pull_factor = coarse ? ACRO_F_COARSE_UP : ACRO_F_FINE_UP;
			default: pull_factor = ACRO_F_ONE;
		endcase
	endfunction : pull_factor

	// a link write spreads the first field that changed to all four
	function automatic logic [11:0] link_write(input logic [11:0] old_v,
		input logic [11:0] new_v, input logic link);
		logic [11:0] res;
		logic found;
		res = new_v;
		found = 1'b0;
		if (link) begin
			for (int i = 0; i < 4; i++) begin
				if (!found && new_v[i*3 +: 3] != old_v[i*3 +: 3]) begin
					found = 1'b1;
					res = {4{new_v[i*3 +: 3]}};
				end
			end
		end
		link_write = res;
	endfunction : link_write

	// effective settings
	logic host_rate;
	acro_rate_t eff_rate;
	acro_pull_t eff_fine;
	acro_pull_t eff_coarse;
	logic vari_on;
	assign host_rate = host.connected && host.frame_internal
		&& ctrl.clk_ref == ACRO_REF_FRAME;
	assign eff_rate = host_rate ? proj_to_base(host.proj_rate)
		: ctrl.rate;
	assign eff_fine = (ctrl.pmode == ACRO_PM_HOST) ? host.fine
		: ctrl.fine;
	assign eff_coarse = (ctrl.pmode == ACRO_PM_HOST) ? host.coarse
		: ctrl.coarse;
	assign vari_on = ctrl.pmode == ACRO_PM_VARI;

	// bus slave: writes land in the data phase, reads take one wait
	// so a read right after a write sees the new value
	logic take;
	logic [11:0] wc_wr;
	logic signed [7:0] vari_wr;
	assign take = i_hsel && i_htrans[1] && i_hready;
	assign wc_wr = link_write(wclk, i_hwdata[11:0], ctrl.wc_link);
	assign vari_wr = i_hwdata[7:0];

	always_comb begin
		next_ctrl = ctrl;
		next_vari = vari;
		next_host = host;
		next_wclk = wclk;
		next_bus_st = bus_st;
		next_wr_pend = 1'b0;
		next_addr = addr;
		next_rdata = rdata;
		next_ready = 1'b1;
		if (wr_pend) begin
			case (addr)
				ACRO_OFF_CTRL: next_ctrl = i_hwdata[13:0];
				ACRO_OFF_VARI: begin
					// clamp keeps the offset inside the allowed span
					if (vari_wr > ACRO_VARI_MAX) begin
						next_vari = ACRO_VARI_MAX;
					end else if (vari_wr < -ACRO_VARI_MAX) begin
						next_vari = -ACRO_VARI_MAX;
					end else begin
						next_vari = vari_wr;
					end
				end
				ACRO_OFF_HOST: next_host = i_hwdata[8:0];
				ACRO_OFF_WCLK: next_wclk = wc_wr;
				default: next_ctrl = ctrl;
			endcase
		end
		case (bus_st)
			ACRO_BUS_IDLE: begin
				if (take) begin
					next_addr = {i_haddr[7:2], 2'b00};
					if (i_hwrite) begin
						next_wr_pend = 1'b1;
					end else begin
						next_bus_st = ACRO_BUS_RD;
						next_ready = 1'b0;
					end
				end
			end
			ACRO_BUS_RD: begin
				next_bus_st = ACRO_BUS_IDLE;
				case (addr)
					ACRO_OFF_CTRL: next_rdata = {18'h0, ctrl};
					ACRO_OFF_VARI: next_rdata = {{24{vari[7]}}, vari};
					ACRO_OFF_HOST: next_rdata = {23'h0, host};
					ACRO_OFF_WCLK: next_rdata = {20'h0, wclk};
					ACRO_OFF_STAT: next_rdata = stat_word;
					ACRO_OFF_INCR: next_rdata = inc;
					default: next_rdata = 32'h0000_0000;
				endcase
			end
			default: next_bus_st = ACRO_BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= ACRO_CTRL_RST;
			vari <= 8'sh00;
			host <= '0;
			wclk <= ACRO_WCLK_RST;
			bus_st <= ACRO_BUS_IDLE;
			wr_pend <= 1'b0;
			addr <= 8'h00;
			rdata <= 32'h0000_0000;
			ready <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			vari <= next_vari;
			host <= next_host;
			wclk <= next_wclk;
			bus_st <= next_bus_st;
			wr_pend <= next_wr_pend;
			addr <= next_addr;
			rdata <= next_rdata;
			ready <= next_ready;
		end
	end

	// speed pipeline: base increment times combined factor
	logic [21:0] fac;
	logic [21:0] next_fac;
	logic [31:0] next_inc;
	logic [31:0] base_inc;
	logic [43:0] pull_prod;
	logic [53:0] inc_prod;
	logic [21:0] vari_fac;

	always_comb begin
		case (eff_rate)
			ACRO_R441: base_inc = ACRO_INC_441;
			ACRO_R32: base_inc = ACRO_INC_32;
			default: base_inc = ACRO_INC_48;
		endcase
		pull_prod = pull_factor(eff_fine, 1'b0)
			* pull_factor(eff_coarse, 1'b1);
		vari_fac = 22'(signed'({1'b0, ACRO_F_ONE})
			+ signed'(vari) * signed'({1'b0, ACRO_F_VARI_STEP}));
		next_fac = vari_on ? vari_fac
			: pull_prod[41:20];
		inc_prod = base_inc * fac;
		next_inc = inc_prod[51:20];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fac <= ACRO_F_ONE;
			inc <= ACRO_INC_48;
		end else begin
			fac <= next_fac;
			inc <= next_inc;
		end
	end

	// reference lock: small frequency trim from the 1x phase at each rising
	// reference edge outside vari mode; trimming the rate avoids any phase jump
	logic ref_sel;
	logic ref_q;
	logic [1:0] trim;
	logic [1:0] next_trim;
	logic [31:0] trim_inc;
	logic tick;
	logic [8:0] div;
	logic [8:0] next_div;

	always_comb begin
		case (ctrl.clk_ref)
			3'h1: ref_sel = i_ref_in[1];
			3'h2: ref_sel = i_ref_in[2];
			3'h3: ref_sel = i_ref_in[3];
			3'h4: ref_sel = i_ref_in[4];
			3'h5: ref_sel = i_ref_in[5];
			default: ref_sel = i_ref_in[0];
		endcase
		next_trim = trim;
		if (vari_on) begin
			next_trim = 2'b00;
		end else if (ref_sel && !ref_q) begin
			if (div == 9'h000) begin
				next_trim = 2'b00;
			end else if (!div[8]) begin
				next_trim = 2'b10;
			end else begin
				next_trim = 2'b01;
			end
		end
		case (trim)
			2'b01: trim_inc = inc + (inc >> ACRO_TRIM_SHIFT);
			2'b10: trim_inc = inc - (inc >> ACRO_TRIM_SHIFT);
			default: trim_inc = inc;
		endcase
		next_div = tick ? div + 9'h001 : div;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_q <= 1'b0;
			trim <= 2'b00;
			div <= 9'h000;
		end else begin
			ref_q <= ref_sel;
			trim <= next_trim;
			div <= next_div;
		end
	end

	acro_nco u_nco (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_inc(trim_inc),
		.o_tick(tick)
	);

	// one counter feeds every multiple, so all stay phase coherent
	logic [7:0] wc_src;
	assign wc_src = {2'b00, div[0], div[6], div[7], div[8],
		i_wc_in, 1'b0};

	logic [3:0] wc_out;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_wc
			acro_clk_sel u_sel (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_src(wc_src),
				.i_sel(wclk[g*3 +: 3]),
				.i_rst_sel(ACRO_WC_X1),
				.o_clk(wc_out[g])
			);
		end
	endgenerate

	assign o_word_clock_out_a = wc_out[0];
	assign o_word_clock_out_b = wc_out[1];
	assign o_word_clock_out_c = wc_out[2];
	assign o_word_clock_out_d = wc_out[3];

	// digital outputs: one shared source for both
	logic [7:0] dig_src;
	assign dig_src = {4'h0, div[7], div[8], i_link_clk, ref_sel};

	acro_clk_sel u_dig (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_src(dig_src),
		.i_sel({1'b0, ctrl.dsrc}),
		.i_rst_sel({1'b0, ACRO_DS_X1}),
		.o_clk(o_dig_clk)
	);

	logic [1:0] link_q;
	logic [1:0] next_link_q;
	always_comb begin
		next_link_q = (ctrl.dsrc == ACRO_DS_LINK) ? i_dig_link_data
			: 2'b00;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_q <= 2'b00;
		end else begin
			link_q <= next_link_q;
		end
	end

	assign stat_word = {22'h0, trim, host_rate, vari_on, eff_coarse,
		eff_fine, eff_rate};

	assign o_dig_link_data = link_q;
	assign o_hrdata = rdata;
	assign o_hreadyout = ready;
	assign o_hresp = 1'b0;

	// size is unused: every access is treated as a whole word
	logic unused_size;
	assign unused_size = ^i_hsize;
endmodule : acro_top

// ---- test/acro_checker.sv ----
// port assertions for the audio clock rate and output block
// assumes i_hready is fed back from o_hreadyout by the bench
`timescale 1ns/10ps
module acro_checker
	import acro_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic [1:0] i_dig_link_data,
	input wire logic o_word_clock_out_a,
	input wire logic o_word_clock_out_b,
	input wire logic o_word_clock_out_d,
	input wire logic o_dig_clk,
	input wire logic [1:0] o_dig_link_data
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_rd;
		i_hsel && i_htrans[1] && i_hready && !i_hwrite;
	endsequence
	sequence s_wr;
		i_hsel && i_htrans[1] && i_hready && i_hwrite;
	endsequence
	sequence s_rd_ans;
		!o_hreadyout ##1 o_hreadyout;
	endsequence
	a_read_one_wait: assert property (s_rd |=> s_rd_ans)
		else $error("read data phase not two cycles");
	a_write_no_wait: assert property (s_wr |=> o_hreadyout)
		else $error("write data phase stalled");
	a_resp_okay: assert property (o_hresp == 1'b0)
		else $error("response not okay");
	a_rdata_stands: assert property ($changed(o_hrdata) |-> !$past(o_hreadyout))
		else $error("read data moved outside a read answer");
	a_link_copy: assert property (o_dig_link_data == 2'b00 ||
		o_dig_link_data == $past(i_dig_link_data))
		else $error("link data neither quiet nor a copy");
	a_no_runt_a: assert property ($rose(o_word_clock_out_a) |->
		o_word_clock_out_a [*4]) else $error("runt pulse on output a");
	a_no_runt_b: assert property ($rose(o_word_clock_out_b) |->
		o_word_clock_out_b [*4]) else $error("runt pulse on output b");
	a_no_runt_d: assert property ($rose(o_word_clock_out_d) |->
		o_word_clock_out_d [*4]) else $error("runt pulse on output d");
	a_no_runt_dig: assert property ($rose(o_dig_clk) |->
		o_dig_clk [*4]) else $error("runt pulse on digital out clock");
	a_rst_quiet: assert property (disable iff (1'b0) !i_rst_n |->
		o_hreadyout && !o_word_clock_out_a && !o_dig_clk)
		else $error("outputs active during reset");
endmodule : acro_checker

bind acro_top acro_checker u_chk (.i_clk, .i_rst_n, .i_hsel, .i_htrans,
	.i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
	.i_dig_link_data, .o_word_clock_out_a, .o_word_clock_out_b,
	.o_word_clock_out_d, .o_dig_clk, .o_dig_link_data);

// ---- test/acro_wc_meter.sv ----
// downstream clock sink: measures rise-to-rise period and counts rises
// assumes the clock line is sampled on the system clock
`timescale 1ns/10ps
module acro_wc_meter (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sig,
	output logic [15:0] o_period,
	output logic [15:0] o_edges
);
	logic prev;
	logic [15:0] cnt;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev <= 1'b0;
			cnt <= 16'h0;
			o_period <= 16'h0;
			o_edges <= 16'h0;
		end else begin
			prev <= i_sig;
			cnt <= cnt + 16'h1;
			if (i_sig && !prev) begin
				o_period <= cnt + 16'h1;
				cnt <= 16'h0;
				o_edges <= o_edges + 16'h1;
			end
		end
	end
endmodule : acro_wc_meter

// ---- test/tb_top.sv ----
// self-checking bench for the audio clock rate and output block
// assumes one 250 MHz clock; reference input toggles only at the end
`timescale 1ns/10ps
module tb_top;
	import acro_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b1;
	logic [5:0] ref_in = 6'h00;
	logic ref_on = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic wc_in = 1'b0;
	logic link_clk = 1'b0;
	logic [1:0] link_data = 2'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [1:0] dlink;
	logic [4:0] outs;
	logic [15:0] per [5];
	logic [15:0] edg [5];
	int bad_count = 0;
	int comparisons = 0;
	int tick = 0;
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		tick <= tick + 1;
		if (tick % 100 == 99)
			wc_in <= ~wc_in;
		if (tick % 50 == 49)
			link_clk <= ~link_clk;
		if (ref_on && tick % 150 == 149)
			ref_in <= ref_in ^ 6'h04;
	end
	acro_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_wc_in(wc_in), .i_ref_in(ref_in), .i_link_clk(link_clk),
		.i_dig_link_data(link_data), .o_word_clock_out_a(outs[0]),
		.o_word_clock_out_b(outs[1]), .o_word_clock_out_c(outs[2]),
		.o_word_clock_out_d(outs[3]), .o_dig_clk(outs[4]),
		.o_dig_link_data(dlink));
	for (genvar g = 0; g < 5; g++) begin : g_meter
		acro_wc_meter u_m (.i_clk(i_clk), .i_rst_n(i_rst_n),
			.i_sig(outs[g]), .o_period(per[g]), .o_edges(edg[g]));
	end
	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	// single transfer; hready is read before this edge's updates land
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input string n, input logic [7:0] a,
		input logic [31:0] m, e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(n, q & m, e);
	endtask : rd_chk
	function automatic logic near(input logic [15:0] v, input int e);
		return int'(v) > e - e / 50 - 3 && int'(v) < e + e / 50 + 3;
	endfunction : near
	function automatic int pexp(input int k);
		return int'(ACRO_SYS_HZ / (ACRO_HZ_48 * k));
	endfunction : pexp
	task automatic t_reset;
		rd_chk("ctrl", ACRO_OFF_CTRL, 32'hffffffff, 32'h2000);
		rd_chk("wclk", ACRO_OFF_WCLK, 32'hfff, 32'h492);
		rd_chk("vari", ACRO_OFF_VARI, 32'hff, 32'h0);
		rd_chk("stat", ACRO_OFF_STAT, 32'hff, 32'h0);
		wr(8'h20, 32'h5);
		rd_chk("unmapped", 8'h20, 32'hffffffff, 32'h0);
	endtask : t_reset
	task automatic t_rate;
		logic [31:0] incs [3];
		logic [31:0] ctl [5];
		logic [31:0] v [5];
		incs = '{ACRO_INC_48, ACRO_INC_441, ACRO_INC_32};
		ctl = '{32'h2008, 32'h2004, 32'h2010, 32'h2020, 32'h2028};
		for (int r = 0; r < 3; r++) begin
			wr(ACRO_OFF_CTRL, 32'h2000 | 32'(r));
			rd_chk("incr", ACRO_OFF_INCR, 32'hffffffff, incs[r]);
			rd_chk("rate", ACRO_OFF_STAT, 32'h3, 32'(r));
		end
		for (int i = 0; i < 5; i++) begin
			wr(ACRO_OFF_CTRL, ctl[i]);
			bus(1'b0, ACRO_OFF_INCR, 32'h0, v[i]);
		end
		check("fine up", 32'(v[0] > ACRO_INC_48), 32'h1);
		check("fine dn", 32'(v[1] < ACRO_INC_48), 32'h1);
		check("coarse dn", 32'(v[2] < v[1]), 32'h1);
		check("both", 32'(v[4] > v[3] && v[3] > v[0]), 32'h1);
	endtask : t_rate
	task automatic t_host;
		wr(ACRO_OFF_HOST, 32'h194);
		wr(ACRO_OFF_CTRL, 32'h2000);
		rd_chk("host 96k", ACRO_OFF_STAT, 32'hff, 32'h80);
		wr(ACRO_OFF_CTRL, 32'h2040);
		rd_chk("host pull", ACRO_OFF_STAT, 32'hff, 32'h88);
		wr(ACRO_OFF_HOST, 32'h195);
		rd_chk("host 176k", ACRO_OFF_STAT, 32'hff, 32'h89);
		wr(ACRO_OFF_HOST, 32'h190);
		rd_chk("host 32k", ACRO_OFF_STAT, 32'hff, 32'h8a);
		wr(ACRO_OFF_CTRL, 32'h2201);
		rd_chk("ref wclk", ACRO_OFF_STAT, 32'hff, 32'h01);
		wr(ACRO_OFF_HOST, 32'h110);
		wr(ACRO_OFF_CTRL, 32'h2025);
		rd_chk("local", ACRO_OFF_STAT, 32'hff, 32'h25);
	endtask : t_host
	task automatic t_vari;
		wr(ACRO_OFF_VARI, 32'h7f);
		rd_chk("vari hi", ACRO_OFF_VARI, 32'hff, 32'h7d);
		wr(ACRO_OFF_VARI, 32'h80);
		rd_chk("vari lo", ACRO_OFF_VARI, 32'hff, 32'h83);
		wr(ACRO_OFF_CTRL, 32'h2080);
		rd_chk("vari on", ACRO_OFF_STAT, 32'h40, 32'h40);
		rd_chk("vari inc", ACRO_OFF_INCR, 32'hffffffff,
			32'((64'(ACRO_INC_48) * (64'h10_0000
			- 64'd125 * 64'(ACRO_F_VARI_STEP))) >> 20));
		wr(ACRO_OFF_VARI, 32'h0);
		wr(ACRO_OFF_CTRL, 32'h2000);
	endtask : t_vari
	task automatic t_wclk;
		int mult [5];
		logic [15:0] n;
		mult = '{1, 2, 4, 256, 1};
		wr(ACRO_OFF_WCLK, 32'hb1a);
		repeat (16000) @(posedge i_clk);
		for (int i = 0; i < 5; i++)
			check("period", near(per[i], pexp(mult[i])), 32'h1);
		wr(ACRO_OFF_WCLK, 32'h488);
		repeat (300) @(posedge i_clk);
		n = edg[0];
		repeat (12000) @(posedge i_clk);
		check("off quiet", edg[0], n);
		check("off low", outs[0], 32'h0);
		check("pass", near(per[1], 200), 32'h1);
		wr(ACRO_OFF_CTRL, 32'h2100);
		wr(ACRO_OFF_WCLK, 32'h48b);
		rd_chk("link", ACRO_OFF_WCLK, 32'hfff, 32'h6db);
		repeat (8000) @(posedge i_clk);
		check("linked c", near(per[2], pexp(2)), 32'h1);
		wr(ACRO_OFF_CTRL, 32'h2000);
	endtask : t_wclk
	task automatic t_dig;
		link_data <= 2'h2;
		wr(ACRO_OFF_CTRL, 32'h1000);
		// old 1x source may stay high for half its period before the swap
		repeat (6000) @(posedge i_clk);
		check("link data", dlink, 32'h2);
		check("link clk", near(per[4], 100), 32'h1);
		wr(ACRO_OFF_CTRL, 32'h3000);
		repeat (8000) @(posedge i_clk);
		check("dig 2x", near(per[4], pexp(2)), 32'h1);
		check("no link data", dlink, 32'h0);
		ref_on <= 1'b1;
		wr(ACRO_OFF_CTRL, 32'h0400);
		repeat (4000) @(posedge i_clk);
		check("dig ref", near(per[4], 300), 32'h1);
		wr(ACRO_OFF_CTRL, 32'h0480);
		rd_chk("vari free", ACRO_OFF_STAT, 32'h300, 32'h0);
	endtask : t_dig
	task automatic tally_and_finish;
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// normal run is near 55000 cycles
	initial begin
		repeat (100000) @(posedge i_clk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		// falling edge at time zero so every flop resets before first clock
		i_rst_n <= 1'b0;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_rate();
		t_host();
		t_vari();
		t_wclk();
		t_dig();
		tally_and_finish();
	end
endmodule : tb_top
